// file: src/hv_status_and_regulator_config.sv
// High-voltage status, sync event counts, pin drive and regulator configuration register bank
`timescale 1ns/10ps
module hv_status_and_regulator_config (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Control port, the only register port that may write configuration
	input  wire logic        ctrlWrEn,
	input  wire logic        ctrlRdEn,
	input  wire logic [6:0]  ctrlAddr,
	input  wire logic [31:0] ctrlWrData,
	output logic      [31:0] ctrlRdData,
	output logic             ctrlRdValid,
	output logic             ctrlAccessErr,
	// Process data mapping port of the network master side
	input  wire logic        mapWrEn,
	input  wire logic        mapRdEn,
	input  wire logic [6:0]  mapAddr,
	output logic      [31:0] mapRdData,
	output logic             mapRdValid,
	output logic             mapAccessDenied,
	// Startup preload from the configuration EEPROM
	input  wire logic        preloadValid,
	input  wire logic        preloadTarget,
	input  wire logic [31:0] preloadData,
	// Analog status lines
	input  wire logic [7:0]  outputOvervoltageSeen,
	input  wire logic [7:0]  groundShortSeen,
	input  wire logic [7:0]  supplyShortSeen,
	input  wire logic        hvOvertempFlag,
	input  wire logic        coreRegShortFlag,
	input  wire logic        adjRegShortFlag,
	input  wire logic        adjRegOvertempFlag,
	// Synchronisation outputs to be counted
	input  wire logic        syncOutputZero,
	input  wire logic        syncOutputOne,
	// Pin drive controls
	output logic      [7:0]  slowEdgeSelect,
	output logic      [7:0]  reducedHighDrive,
	output logic      [7:0]  reducedLowDrive,
	output logic      [3:0]  differentialPairEnable,
	// Core regulator controls
	output logic      [1:0]  coreRegFrequency,
	output logic      [1:0]  coreRegGain,
	output logic      [1:0]  coreRegDamping,
	output logic             coreRegProtectOff,
	// Adjustable regulator controls
	output logic      [1:0]  adjRegFrequency,
	output logic      [1:0]  adjRegGain,
	output logic      [1:0]  adjRegDamping,
	output logic             adjRegProtectOff,
	output logic             adjRegOff
);

	// State of the bank, apart from the sync counters, in one record
	typedef struct packed {
		logic [31:0] statusWord;   // Sampled analog status
		logic [31:0] pinCfg;       // Pin drive and pairing configuration
		logic [15:0] regCfg;       // Regulator configuration
		logic [31:0] ctrlData;     // Control port read answer
		logic        ctrlValid;    // Control port answer strobe
		logic        ctrlErr;      // Control port refusal strobe
		logic [31:0] mapData;      // Mapping port read answer
		logic        mapValid;     // Mapping port answer strobe
		logic        mapDenied;    // Mapping port refusal strobe
	} bank_state_t;

	bank_state_t state_q;  // Registered state
	bank_state_t state_d;  // Next state

	logic [hv_status_pkg::SYNC_CNT_W-1:0] syncCount0;  // Events on sync output zero
	logic [hv_status_pkg::SYNC_CNT_W-1:0] syncCount1;  // Events on sync output one
	logic [31:0]                          countsWord;  // Both counts as one word
	logic [31:0]                          statusNow;   // Status lines assembled this cycle
	hv_status_pkg::reg_sel_t              ctrlSel;     // Register picked by control port
	hv_status_pkg::reg_sel_t              mapSel;      // Register picked by mapping port

	// Map a register number to the register it names
	function automatic hv_status_pkg::reg_sel_t decodeReg(input logic [6:0] addr);
		hv_status_pkg::reg_sel_t sel;
		sel = hv_status_pkg::SEL_NONE;
		case (addr)
			hv_status_pkg::REG_HV_STATUS: begin
				sel = hv_status_pkg::SEL_STATUS;
			end
			hv_status_pkg::REG_SYNC_COUNTS: begin
				sel = hv_status_pkg::SEL_COUNTS;
			end
			hv_status_pkg::REG_HV_PIN_CFG: begin
				sel = hv_status_pkg::SEL_PIN_CFG;
			end
			hv_status_pkg::REG_REGULATOR_CFG: begin
				sel = hv_status_pkg::SEL_REG_CFG;
			end
			default: begin
				sel = hv_status_pkg::SEL_NONE;
			end
		endcase
		return sel;
	endfunction : decodeReg

	// One counter per sync output; both share the same module
	sync_event_counter #(
		.CNT_W      (hv_status_pkg::SYNC_CNT_W)
	) u_count_zero (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.syncPulse  (syncOutputZero),
		.eventCount (syncCount0)
	);

	sync_event_counter #(
		.CNT_W      (hv_status_pkg::SYNC_CNT_W)
	) u_count_one (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.syncPulse  (syncOutputOne),
		.eventCount (syncCount1)
	);

	// Pack both counts: zero in the low half, one in the high half
	assign countsWord = {syncCount1, syncCount0};

	// Gather the status lines into their documented positions
	always_comb begin
		statusNow = 32'h00000000;  // Bits 31:28 stay zero
		statusNow[hv_status_pkg::ST_OVERVOLT_LSB +: 8]  = outputOvervoltageSeen;
		statusNow[hv_status_pkg::ST_GND_SHORT_LSB +: 8] = groundShortSeen;
		statusNow[hv_status_pkg::ST_SUP_SHORT_LSB +: 8] = supplyShortSeen;
		statusNow[hv_status_pkg::ST_HV_OT_BIT]          = hvOvertempFlag;
		statusNow[hv_status_pkg::ST_CORE_SC_BIT]        = coreRegShortFlag;
		statusNow[hv_status_pkg::ST_ADJ_SC_BIT]         = adjRegShortFlag;
		statusNow[hv_status_pkg::ST_ADJ_OT_BIT]         = adjRegOvertempFlag;
	end

	// Decode both ports once
	assign ctrlSel = decodeReg(ctrlAddr);
	assign mapSel  = decodeReg(mapAddr);

	// Next-state logic of the bank
	always_comb begin
		state_d = state_q;
		// Answer strobes last one cycle
		state_d.ctrlValid = 1'b0;
		state_d.ctrlErr   = 1'b0;
		state_d.mapValid  = 1'b0;
		state_d.mapDenied = 1'b0;
		// Status is live: resampled every cycle, no latching of events
		state_d.statusWord = statusNow;

		// Preload first, so a control write in the same cycle overrides it
		if (preloadValid) begin
			if (preloadTarget == hv_status_pkg::LOAD_REG_CFG) begin
				state_d.regCfg = preloadData[hv_status_pkg::REG_CFG_W-1:0];
			end else begin
				state_d.pinCfg = preloadData & hv_status_pkg::PC_WRITE_MASK;
			end
		end

		// Control port writes; only the two configuration registers take them
		if (ctrlWrEn) begin
			case (ctrlSel)
				hv_status_pkg::SEL_PIN_CFG: begin
					// Reserved top nibble is not stored
					state_d.pinCfg = ctrlWrData & hv_status_pkg::PC_WRITE_MASK;
				end
				hv_status_pkg::SEL_REG_CFG: begin
					// Bit 7 is reserved but writable; it is kept and drives nothing
					state_d.regCfg = ctrlWrData[hv_status_pkg::REG_CFG_W-1:0];
				end
				default: begin
					// Read-only or unmapped: refused, nothing stored
					state_d.ctrlErr = 1'b1;
				end
			endcase
		end

		// Control port reads; a read with a write in the same cycle still answers
		if (ctrlRdEn) begin
			state_d.ctrlValid = 1'b1;
			state_d.ctrlData  = 32'h00000000;
			case (ctrlSel)
				hv_status_pkg::SEL_STATUS: begin
					state_d.ctrlData = state_q.statusWord;
				end
				hv_status_pkg::SEL_COUNTS: begin
					// Counts are not visible here; answer zero and flag it
					state_d.ctrlErr = 1'b1;
				end
				hv_status_pkg::SEL_PIN_CFG: begin
					// Write-only configuration reads back as zero
					state_d.ctrlData = 32'h00000000;
				end
				hv_status_pkg::SEL_REG_CFG: begin
					state_d.ctrlData = 32'h00000000;
				end
				default: begin
					state_d.ctrlErr = 1'b1;
				end
			endcase
		end

		// Mapping port never writes anything in this bank
		if (mapWrEn) begin
			state_d.mapDenied = 1'b1;
		end

		// Mapping port reads: status and counts only
		if (mapRdEn) begin
			state_d.mapValid = 1'b1;
			state_d.mapData  = 32'h00000000;
			case (mapSel)
				hv_status_pkg::SEL_STATUS: begin
					state_d.mapData = state_q.statusWord;
				end
				hv_status_pkg::SEL_COUNTS: begin
					// Plain copy; the counters see no read strobe at all
					state_d.mapData = countsWord;
				end
				hv_status_pkg::SEL_PIN_CFG: begin
					state_d.mapDenied = 1'b1;
				end
				hv_status_pkg::SEL_REG_CFG: begin
					state_d.mapDenied = 1'b1;
				end
				default: begin
					state_d.mapDenied = 1'b1;
				end
			endcase
		end
	end

	// State register; configuration comes up all zero
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q.statusWord <= 32'h00000000;
			state_q.pinCfg     <= hv_status_pkg::PIN_CFG_RESET;
			state_q.regCfg     <= hv_status_pkg::REG_CFG_RESET;
			state_q.ctrlData   <= 32'h00000000;
			state_q.ctrlValid  <= 1'b0;
			state_q.ctrlErr    <= 1'b0;
			state_q.mapData    <= 32'h00000000;
			state_q.mapValid   <= 1'b0;
			state_q.mapDenied  <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// Register port answers
	assign ctrlRdData      = state_q.ctrlData;
	assign ctrlRdValid     = state_q.ctrlValid;
	assign ctrlAccessErr   = state_q.ctrlErr;
	assign mapRdData       = state_q.mapData;
	assign mapRdValid      = state_q.mapValid;
	assign mapAccessDenied = state_q.mapDenied;

	// Pin drive fields, one bit per high-voltage line
	assign slowEdgeSelect         = state_q.pinCfg[hv_status_pkg::PC_SLOW_LSB +: 8];
	assign reducedHighDrive       = state_q.pinCfg[hv_status_pkg::PC_WEAK_HIGH_LSB +: 8];
	assign reducedLowDrive        = state_q.pinCfg[hv_status_pkg::PC_WEAK_LOW_LSB +: 8];
	// Pairs: 0 joins 3&0, 1 joins 4&1, 2 joins 5&2, 3 joins 7&6
	assign differentialPairEnable = state_q.pinCfg[hv_status_pkg::PC_DIFF_LSB +: 4];

	// Core regulator fields; codes go to the analog side unchanged
	assign coreRegFrequency  = state_q.regCfg[hv_status_pkg::RC_CORE_FREQ_LSB +: 2];
	assign coreRegGain       = state_q.regCfg[hv_status_pkg::RC_CORE_GAIN_LSB +: 2];
	assign coreRegDamping    = state_q.regCfg[hv_status_pkg::RC_CORE_DAMP_LSB +: 2];
	assign coreRegProtectOff = state_q.regCfg[hv_status_pkg::RC_CORE_PROT_BIT];

	// Adjustable regulator fields
	assign adjRegFrequency  = state_q.regCfg[hv_status_pkg::RC_ADJ_FREQ_LSB +: 2];
	assign adjRegGain       = state_q.regCfg[hv_status_pkg::RC_ADJ_GAIN_LSB +: 2];
	assign adjRegDamping    = state_q.regCfg[hv_status_pkg::RC_ADJ_DAMP_LSB +: 2];
	assign adjRegProtectOff = state_q.regCfg[hv_status_pkg::RC_ADJ_PROT_BIT];
	assign adjRegOff        = state_q.regCfg[hv_status_pkg::RC_ADJ_OFF_BIT];

endmodule : hv_status_and_regulator_config

// file: src/hv_status_pkg.sv
// Constants, register map and field layout of the high-voltage status and regulator configuration bank
package hv_status_pkg;

	// Register numbers as printed; the port carries the number itself
	localparam int          ADDR_W             = 7;
	localparam logic [6:0]  REG_HV_STATUS      = 7'h3B;  // Register 59
	localparam logic [6:0]  REG_SYNC_COUNTS    = 7'h3F;  // Register 63
	localparam logic [6:0]  REG_HV_PIN_CFG     = 7'h40;  // Register 64
	localparam logic [6:0]  REG_REGULATOR_CFG  = 7'h41;  // Register 65

	// Widths
	localparam int          DATA_W             = 32;
	localparam int          HV_LINES           = 8;
	localparam int          PAIR_COUNT         = 4;
	localparam int          SYNC_CNT_W         = 16;
	localparam int          REG_CFG_W          = 16;

	// Status word field positions
	localparam int          ST_OVERVOLT_LSB    = 0;
	localparam int          ST_GND_SHORT_LSB   = 8;
	localparam int          ST_SUP_SHORT_LSB   = 16;
	localparam int          ST_HV_OT_BIT       = 24;
	localparam int          ST_CORE_SC_BIT     = 25;
	localparam int          ST_ADJ_SC_BIT      = 26;
	localparam int          ST_ADJ_OT_BIT      = 27;

	// Pin configuration field positions
	localparam int          PC_SLOW_LSB        = 0;
	localparam int          PC_WEAK_HIGH_LSB   = 8;
	localparam int          PC_WEAK_LOW_LSB    = 16;
	localparam int          PC_DIFF_LSB        = 24;
	localparam logic [31:0] PC_WRITE_MASK      = 32'h0FFFFFFF;

	// Regulator configuration field positions
	localparam int          RC_CORE_FREQ_LSB   = 0;
	localparam int          RC_CORE_GAIN_LSB   = 2;
	localparam int          RC_CORE_DAMP_LSB   = 4;
	localparam int          RC_CORE_PROT_BIT   = 6;
	localparam int          RC_ADJ_FREQ_LSB    = 8;
	localparam int          RC_ADJ_GAIN_LSB    = 10;
	localparam int          RC_ADJ_DAMP_LSB    = 12;
	localparam int          RC_ADJ_PROT_BIT    = 14;
	localparam int          RC_ADJ_OFF_BIT     = 15;

	// Values after reset
	localparam logic [31:0] PIN_CFG_RESET      = 32'h00000000;
	localparam logic [15:0] REG_CFG_RESET      = 16'h0000;
	localparam logic [15:0] SYNC_CNT_RESET     = 16'h0000;

	// Which register an address selects
	typedef enum logic [2:0] {
		SEL_NONE    = 3'h0,
		SEL_STATUS  = 3'h1,
		SEL_COUNTS  = 3'h3,
		SEL_PIN_CFG = 3'h2,
		SEL_REG_CFG = 3'h6
	} reg_sel_t;

	// Preload target from the configuration loader
	typedef enum logic {
		LOAD_PIN_CFG = 1'b0,
		LOAD_REG_CFG = 1'b1
	} load_target_t;

endpackage : hv_status_pkg

// file: src/sync_event_counter.sv
// Free-running wrap-around counter of rising edges on one sync output
`timescale 1ns/10ps
module sync_event_counter #(
	parameter int CNT_W = hv_status_pkg::SYNC_CNT_W
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             syncPulse,
	output logic      [CNT_W-1:0] eventCount
);

	// Whole state in one record
	typedef struct packed {
		logic             prevLevel;  // Level of the sync line one cycle ago
		logic [CNT_W-1:0] count;      // Events seen so far
	} cnt_state_t;

	cnt_state_t state_q;  // Registered state
	cnt_state_t state_d;  // Next state

	// Count each rising edge; no read path touches the count
	always_comb begin
		state_d           = state_q;
		state_d.prevLevel = syncPulse;
		// A high level held for many cycles counts once, not once per cycle
		if (syncPulse && !state_q.prevLevel) begin
			state_d.count = state_q.count + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Reset to zero, otherwise never cleared
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q.prevLevel <= 1'b0;
			state_q.count     <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Straight from the flip-flops
	assign eventCount = state_q.count;

endmodule : sync_event_counter

// file: testbench/hv_status_checker.sv
// Concurrent checks on the ports of the status and regulator configuration bank
`timescale 1ns/10ps
module hv_status_checker (
	input	wire logic			ref_clk,
	input	wire logic			sys_rst,
	input	wire logic			ctrlWrEn,
	input	wire logic			ctrlRdEn,
	input	wire logic	[6:0]	ctrlAddr,
	input	wire logic	[31:0]	ctrlWrData,
	input	wire logic	[31:0]	ctrlRdData,
	input	wire logic			ctrlRdValid,
	input	wire logic			ctrlAccessErr,
	input	wire logic			mapWrEn,
	input	wire logic			mapRdEn,
	input	wire logic	[6:0]	mapAddr,
	input	wire logic	[31:0]	mapRdData,
	input	wire logic			mapRdValid,
	input	wire logic			mapAccessDenied,
	input	wire logic			preloadValid,
	input	wire logic	[7:0]	outputOvervoltageSeen,
	input	wire logic	[7:0]	slowEdgeSelect,
	input	wire logic	[3:0]	differentialPairEnable,
	input	wire logic			coreRegProtectOff,
	input	wire logic			adjRegOff
);
	logic	[31:0]	wrDataQ;	// Write data of the previous cycle

	// Delayed copy so a stored field can be tied to the data that wrote it
	always_ff @(posedge ref_clk) begin
		wrDataQ <= ctrlWrData;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// A control read of the counts and its refusal one cycle later
	sequence sCountRead;
		ctrlRdEn && ctrlAddr == 7'h3F;
	endsequence
	sequence sRefused;
		ctrlAccessErr && ctrlRdValid && ctrlRdData == 32'h00000000;
	endsequence

	a_count_ctrl_refused: assert property (sCountRead |=> sRefused)
		else $error("control read of counts not refused");
	a_ctrl_valid_pulse: assert property (ctrlRdValid == $past(ctrlRdEn))
		else $error("control read answer out of step");
	a_map_valid_pulse: assert property (mapRdValid == $past(mapRdEn))
		else $error("mapping read answer out of step");
	a_map_cfg_denied: assert property ((mapWrEn || (mapRdEn && mapAddr inside {7'h40, 7'h41}))
		|=> mapAccessDenied)
		else $error("mapping access to configuration not denied");
	a_pin_cfg_write: assert property (ctrlWrEn && ctrlAddr == 7'h40 |=> slowEdgeSelect == wrDataQ[7:0]
		&& differentialPairEnable == wrDataQ[27:24])
		else $error("pin configuration not taken from write");
	a_reg_cfg_write: assert property (ctrlWrEn && ctrlAddr == 7'h41 |=> adjRegOff == wrDataQ[15]
		&& coreRegProtectOff == wrDataQ[6])
		else $error("regulator configuration not taken from write");
	a_cfg_held_still: assert property (!ctrlWrEn && !preloadValid |=> $stable(slowEdgeSelect)
		&& $stable(adjRegOff))
		else $error("configuration changed without a write");
	a_status_tracks: assert property (ctrlRdEn && ctrlAddr == 7'h3B
		|=> ctrlRdData[7:0] == $past(outputOvervoltageSeen, 2))
		else $error("status read does not show overvoltage lines");
endmodule : hv_status_checker

bind hv_status_and_regulator_config hv_status_checker chk (.ref_clk, .sys_rst, .ctrlWrEn, .ctrlRdEn, .ctrlAddr,
	.ctrlWrData, .ctrlRdData, .ctrlRdValid, .ctrlAccessErr, .mapWrEn, .mapRdEn, .mapAddr, .mapRdData,
	.mapRdValid, .mapAccessDenied, .preloadValid, .outputOvervoltageSeen, .slowEdgeSelect,
	.differentialPairEnable, .coreRegProtectOff, .adjRegOff);

// file: testbench/ctrl_host.sv
// Host processor model issuing single accesses on the control port
`timescale 1ns/10ps
module ctrl_host (
	input	wire logic			ref_clk,
	output	logic				ctrlWrEn,
	output	logic				ctrlRdEn,
	output	logic		[6:0]	ctrlAddr,
	output	logic		[31:0]	ctrlWrData
);
	// Idle port at time zero
	initial begin
		ctrlWrEn = 1'b0;
		ctrlRdEn = 1'b0;
		ctrlAddr = 7'h00;
		ctrlWrData = 32'h00000000;
	end

	// One-cycle request; released address and data show inverted values, enables drop to zero, so stale data never looks valid
	task automatic access(input logic wr, input logic [6:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		ctrlWrEn <= wr;
		ctrlRdEn <= !wr;
		ctrlAddr <= a;
		ctrlWrData <= d;
		@(posedge ref_clk);
		ctrlWrEn <= 1'b0;
		ctrlRdEn <= 1'b0;
		ctrlAddr <= ~a;
		ctrlWrData <= ~d;
		#1;
	endtask : access
endmodule : ctrl_host

// file: testbench/tb.sv
// Self-checking bench for the status and regulator configuration bank
`timescale 1ns/10ps
module tb;
	logic			ref_clk, sys_rst, ctrlWrEn, ctrlRdEn, ctrlRdValid, ctrlAccessErr;	// Clock, control
	logic	[6:0]	ctrlAddr, mapAddr;											// Register numbers
	logic	[31:0]	ctrlWrData, ctrlRdData, mapRdData, preloadData;				// Data words
	logic			mapWrEn, mapRdEn, mapRdValid, mapAccessDenied, preloadValid, preloadTarget;
	logic	[7:0]	outputOvervoltageSeen, groundShortSeen, supplyShortSeen;	// Status lines
	logic			hvOvertempFlag, coreRegShortFlag, adjRegShortFlag, adjRegOvertempFlag;
	logic			syncOutputZero, syncOutputOne;								// Counted events
	logic	[7:0]	slowEdgeSelect, reducedHighDrive, reducedLowDrive;			// Pin drive
	logic	[3:0]	differentialPairEnable;
	logic	[1:0]	coreRegFrequency, coreRegGain, coreRegDamping, adjRegFrequency, adjRegGain, adjRegDamping;
	logic			coreRegProtectOff, adjRegProtectOff, adjRegOff;
	int				errors, comparisons, cycles;								// Tallies
	logic	[15:0]	d;															// Regulator word

	hv_status_and_regulator_config dut (.ref_clk, .sys_rst, .ctrlWrEn, .ctrlRdEn, .ctrlAddr, .ctrlWrData,
		.ctrlRdData, .ctrlRdValid, .ctrlAccessErr, .mapWrEn, .mapRdEn, .mapAddr, .mapRdData, .mapRdValid,
		.mapAccessDenied, .preloadValid, .preloadTarget, .preloadData, .outputOvervoltageSeen,
		.groundShortSeen, .supplyShortSeen, .hvOvertempFlag, .coreRegShortFlag, .adjRegShortFlag,
		.adjRegOvertempFlag, .syncOutputZero, .syncOutputOne, .slowEdgeSelect, .reducedHighDrive,
		.reducedLowDrive, .differentialPairEnable, .coreRegFrequency, .coreRegGain, .coreRegDamping,
		.coreRegProtectOff, .adjRegFrequency, .adjRegGain, .adjRegDamping, .adjRegProtectOff, .adjRegOff);
	ctrl_host host (.ref_clk, .ctrlWrEn, .ctrlRdEn, .ctrlAddr, .ctrlWrData);

	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Cut a hang short; the whole run needs about a hundred cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			test_done();
		end
	end

	// Drive outputs packed back into register layout
	function automatic logic [31:0] pinCfg();
		return {4'h0, differentialPairEnable, reducedLowDrive, reducedHighDrive, slowEdgeSelect};
	endfunction : pinCfg
	function automatic logic [31:0] regCfg();
		return {16'h0000, adjRegOff, adjRegProtectOff, adjRegDamping, adjRegGain, adjRegFrequency, 1'b0,
			coreRegProtectOff, coreRegDamping, coreRegGain, coreRegFrequency};
	endfunction : regCfg

	// Word and flag comparisons
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkBit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chkBit

	// Control read and write through the host model
	task automatic rd(input logic [6:0] a, input logic [31:0] exp, input logic err);
		host.access(1'b0, a, 32'h00000000);
		chkBit(ctrlRdValid, 1'b1);
		chkBit(ctrlAccessErr, err);
		chk(ctrlRdData, exp);
	endtask : rd
	task automatic wr(input logic [6:0] a, input logic [31:0] dat, input logic err);
		host.access(1'b1, a, dat);
		chkBit(ctrlAccessErr, err);
	endtask : wr

	// Mapping port access; a write is always a refused attempt
	task automatic macc(input logic w, input logic [6:0] a, input logic [31:0] exp, input logic den);
		@(posedge ref_clk);
		mapWrEn <= w;
		mapRdEn <= !w;
		mapAddr <= a;
		@(posedge ref_clk);
		mapWrEn <= 1'b0;
		mapRdEn <= 1'b0;
		mapAddr <= ~a;
		#1;
		chkBit(mapAccessDenied, den);
		chkBit(mapRdValid, !w);
		if (!w) chk(mapRdData, exp);
	endtask : macc

	// Startup preload strobe
	task automatic pre(input logic t, input logic [31:0] dat);
		@(posedge ref_clk);
		preloadValid <= 1'b1;
		preloadTarget <= t;
		preloadData <= dat;
		@(posedge ref_clk);
		preloadValid <= 1'b0;
		preloadData <= ~dat;
		#1;
	endtask : pre

	// Rising edges on the sync outputs, low between them
	task automatic pulses(input int n0, input int n1);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			syncOutputZero <= (i < n0);
			syncOutputOne <= (i < n1);
			@(posedge ref_clk);
			syncOutputZero <= 1'b0;
			syncOutputOne <= 1'b0;
		end
	endtask : pulses

	// Verdict
	task automatic test_done();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done

	// Main sequence
	initial begin
		// Reset held from time zero; the mapping and preload lines start idle
		sys_rst = 1'b1;
		{mapWrEn, mapRdEn, mapAddr, preloadValid, preloadTarget, preloadData} = '0;
		{outputOvervoltageSeen, groundShortSeen, supplyShortSeen} = 24'h000000;
		{hvOvertempFlag, coreRegShortFlag, adjRegShortFlag, adjRegOvertempFlag} = 4'h0;
		{syncOutputZero, syncOutputOne, errors, comparisons, cycles} = '0;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk(pinCfg(), 32'h00000000);
		chk(regCfg(), 32'h00000000);
		macc(1'b0, 7'h3F, 32'h00000000, 1'b0);
		// Status word through both ports, then on the control port with the overtemperature and core short flags swapped
		{outputOvervoltageSeen, groundShortSeen, supplyShortSeen} <= 24'hA53C81;
		{hvOvertempFlag, coreRegShortFlag, adjRegShortFlag, adjRegOvertempFlag} <= 4'hB;
		repeat (2) @(posedge ref_clk);
		rd(7'h3B, 32'h0D813CA5, 1'b0);
		macc(1'b0, 7'h3B, 32'h0D813CA5, 1'b0);
		{hvOvertempFlag, coreRegShortFlag, outputOvervoltageSeen} <= 10'h15A;
		repeat (2) @(posedge ref_clk);
		rd(7'h3B, 32'h0E813C5A, 1'b0);
		// Event counts, repeated reads, refused control read, further counting
		pulses(5, 3);
		macc(1'b0, 7'h3F, 32'h00030005, 1'b0);
		macc(1'b0, 7'h3F, 32'h00030005, 1'b0);
		rd(7'h3F, 32'h00000000, 1'b1);
		pulses(1, 2);
		macc(1'b0, 7'h3F, 32'h00050006, 1'b0);
		// Pin configuration; mapping side may neither read nor write it
		wr(7'h40, 32'hFEDCBA98, 1'b0);
		chk(pinCfg(), 32'h0EDCBA98);
		rd(7'h40, 32'h00000000, 1'b0);
		macc(1'b1, 7'h40, 32'h00000000, 1'b1);
		macc(1'b0, 7'h40, 32'h00000000, 1'b1);
		macc(1'b0, 7'h41, 32'h00000000, 1'b1);
		chk(pinCfg(), 32'h0EDCBA98);
		wr(7'h3B, 32'hFFFFFFFF, 1'b1);
		rd(7'h7F, 32'h00000000, 1'b1);
		// Every code of every regulator field, protection and off bits varied
		for (int k = 0; k < 4; k++) begin
			d = 16'(k) * 16'h1515;
			d[6] = k[0];
			d[14] = k[1];
			d[15] = k[0] ^ k[1];
			wr(7'h41, {16'hFFFF, d}, 1'b0);
			chk(regCfg(), {16'h0000, d});
		end
		pre(1'b0, 32'h01234567);
		chk(pinCfg(), 32'h01234567);
		pre(1'b1, 32'h0000C000);
		chk(regCfg(), 32'h0000C000);
		// Second reset in mid-run, raised on a clock edge like every other input
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk(pinCfg() | regCfg(), 32'h00000000);
		macc(1'b0, 7'h3F, 32'h00000000, 1'b0);
		test_done();
	end
endmodule : tb
